/* dv/host_model.sv */
`timescale 1ns/1ps

module host_model (
    input wire logic clk,
    input wire logic line_oe,
    output logic line_level,
    output logic pwm_level
);
    logic host_q;

    // Line has a pull-up, so a released host reads high unless the device pulls it
    assign line_level = host_q & ~line_oe;

    initial begin
        host_q = 1'b0;
        pwm_level = 1'b0;
    end

    // Called at a falling edge; the level stands for n falling edges
    task automatic hold(input logic v, input int n);
        host_q = v;
        repeat (n) @(negedge clk);
    endtask : hold

    task automatic set_pwm(input logic v);
        pwm_level = v;
    endtask : set_pwm

    // Serial entry keeps pwm high from the start; first high outlasts the 2500-cycle entry time
    task automatic power_up(input logic serial);
        pwm_level = 1'b1;
        hold(1'b1, 2600);
        if (serial) begin
            hold(1'b0, 80);
        end
        hold(1'b1, 10);
    endtask : power_up

    // Each bit is a low phase then a high phase; zl sets the zero-bit low time
    task automatic send_bit(input logic b, input int zl);
        if (b) begin
            hold(1'b0, 60);
            hold(1'b1, 150);
        end else begin
            hold(1'b0, zl);
            hold(1'b1, 60);
        end
    endtask : send_bit

    // Ends with the line released high, so an acknowledge may follow at once
    task automatic send_frame(input logic [23:0] cmd, input int zl);
        hold(1'b1, 60);
        for (int i = 0; i < 24; i++) begin
            send_bit(cmd[i], zl);
        end
        hold(1'b0, 100);
        host_q = 1'b1;
    endtask : send_frame
endmodule : host_model

/* dv/tb_one_wire_dimming_control.sv */
`timescale 1ns/1ps

module tb_one_wire_dimming_control;
    localparam int SEL = 3000;
    localparam int DLY = 100;
    localparam int ENOFF = 1000;
    localparam int PWMOFF = 2000;
    localparam int ACKN = 12800;
    logic clk;
    logic reset_n = 1'b0;
    logic line_level;
    logic pwm_level;
    logic line_pull;
    logic line_oe;
    one_wire_dimming_pkg::sink_ctrl_s sink_ctrl;
    one_wire_dimming_pkg::drive_status_s drive_status;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    logic oe_prev = 1'b0;
    int oe_rises = 0;

    // Short window, delay and timeouts keep the run small; the entry low stays below the
    // line timeout, while entry high, bit limits and acknowledge length keep real values
    one_wire_dimming_control #(.SEL_CYC(SEL), .ENTRY_LOW_CYC(50), .EN_OFF_CYC(ENOFF),
        .PWM_OFF_CYC(PWMOFF), .DELAY_CYC(DLY)) one_wire_dimming_control_inst (
        .clk(clk),
        .reset_n(reset_n),
        .single_wire_line_level(line_level),
        .pwm_dim_level(pwm_level),
        .single_wire_line_pull(line_pull),
        .single_wire_line_oe(line_oe),
        .sink_ctrl(sink_ctrl),
        .drive_status(drive_status)
    );

    host_model host_model_inst (
        .clk(clk),
        .line_oe(line_oe),
        .line_level(line_level),
        .pwm_level(pwm_level)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Cycle count and a count of acknowledge pulses for the checks
    always @(posedge clk) begin
        cyc <= cyc + 1;
        oe_prev <= line_oe;
        if (line_oe === 1'b1 && oe_prev !== 1'b1) begin
            oe_rises <= oe_rises + 1;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    task automatic do_reset();
        host_model_inst.hold(1'b0, 0);
        host_model_inst.set_pwm(1'b0);
        reset_n = 1'b0;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask : do_reset

    // Power up and return the cycles until the boost starts
    task automatic start(input logic serial, output int d);
        int t0;
        t0 = cyc;
        host_model_inst.power_up(serial);
        for (int i = 0; i < SEL + DLY + 50 && drive_status.boost_on !== 1'b1; i++) begin
            @(negedge clk);
        end
        d = cyc - t0;
    endtask : start

    task automatic t_pwm();
        int d;
        do_reset();
        start(1'b0, d);
        check(d >= SEL + DLY && d <= SEL + DLY + 10, 1, "boost delay");
        check(drive_status.serial_mode, 0, "fallback mode");
        check(sink_ctrl.current_sink_one_on, 1, "sink one on");
        check(sink_ctrl.level, 8'hFF, "pwm level");
        host_model_inst.set_pwm(1'b0);
        repeat (50) @(negedge clk);
        check(sink_ctrl.current_sink_two_on, 0, "sink follows pwm");
        check(drive_status.enabled, 1, "short pwm low");
        repeat (PWMOFF) @(negedge clk);
        check(drive_status.enabled, 0, "pwm shutdown");
        $display("test pwm done");
    endtask : t_pwm

    // One frame; with ack, times the acknowledge from the host release
    task automatic frame(input logic [23:0] cmd, input int zl, input logic ack);
        int d;
        int a0;
        a0 = oe_rises;
        host_model_inst.send_frame(cmd, zl);
        if (ack) begin
            d = 0;
            while (d < 50 && line_oe !== 1'b1) begin
                @(negedge clk);
                d++;
            end
            check(d < 50, 1, "ack delay");
            check(line_level, 0, "line held low");
            check(line_pull, 0, "pull drives low");
            d = 0;
            while (d < ACKN + 20 && line_oe === 1'b1) begin
                @(negedge clk);
                d++;
            end
            check(d >= ACKN - 2 && d <= ACKN, 1, "ack length");
            check(drive_status.ack_active, 1, "ack status trails pin");
        end
        repeat (10) @(negedge clk);
        check(8'(oe_rises - a0), ack, "ack presence");
        check(drive_status.ack_active, 0, "ack status clear");
    endtask : frame

    task automatic t_serial();
        int d;
        do_reset();
        start(1'b1, d);
        check(drive_status.serial_mode, 1, "serial entry");
        check(sink_ctrl.level, 8'hFF, "default level");
        frame({8'h8F, 16'h00B4}, 120, 1'b0);
        check(sink_ctrl.level, 8'h5A, "level write");
        frame({8'h8F, 16'h0466}, 150, 1'b1);
        check(sink_ctrl.level, 8'h33, "level with ack");
        frame({8'h8E, 16'h0022}, 150, 1'b0);
        check(sink_ctrl.level, 8'h33, "wrong address");
        frame({8'h8F, 16'h0022}, 100, 1'b0);
        check(sink_ctrl.level, 8'h33, "bad ratio");
        $display("test serial done");
    endtask : t_serial

    // Continues from the serial state; the loaded level must not survive shutdown
    task automatic t_shutdown();
        int d;
        host_model_inst.hold(1'b0, ENOFF - 100);
        check(drive_status.enabled, 1, "short line low");
        host_model_inst.hold(1'b0, 120);
        check(drive_status.enabled, 0, "line shutdown");
        check(sink_ctrl.current_sink_one_on, 0, "sinks off");
        check(sink_ctrl.level, 8'hFF, "level cleared");
        start(1'b0, d);
        check(drive_status.serial_mode, 0, "mode chosen again");
        check(sink_ctrl.level, 8'hFF, "level reinitialised");
        $display("test shutdown done");
    endtask : t_shutdown

    initial begin
        t_pwm();
        t_serial();
        t_shutdown();
        summarize();
    end

    // The run needs about 1.8 ms; a hang is cut after 3 ms
    initial begin
        #3000000;
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        summarize();
    end
endmodule : tb_one_wire_dimming_control

/* rtl/one_wire_dimming_control.sv */
`timescale 1ns/1ps
`include "one_wire_dimming_defines.svh"

module one_wire_dimming_control #(
    parameter int TW = 20,
    parameter int SEL_CYC = (`SEL_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int ENTRY_HIGH_CYC = (`ENTRY_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int ENTRY_LOW_CYC = (`ENTRY_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int EN_OFF_CYC = (`EN_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int PWM_OFF_CYC = (`PWM_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int DELAY_CYC = `START_DELAY_NS / `CLK_PERIOD_NS,
    parameter int SHORT_MAX_CYC = `BIT_SHORT_MAX_NS / `CLK_PERIOD_NS,
    parameter int LONG_MAX_CYC = `BIT_LONG_MAX_NS / `CLK_PERIOD_NS,
    parameter int ACK_CYC = `ACK_MAX_NS / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic single_wire_line_level,
    input wire logic pwm_dim_level,
    output logic single_wire_line_pull,
    output logic single_wire_line_oe,
    output one_wire_dimming_pkg::sink_ctrl_s sink_ctrl,
    output one_wire_dimming_pkg::drive_status_s drive_status
);
    localparam int MIN_CYC = (`PHASE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam logic [TW-1:0] SEL_LAST = TW'(SEL_CYC - 1);
    localparam logic [TW-1:0] DELAY_LAST = TW'(DELAY_CYC - 1);
    localparam logic [TW-1:0] ACK_LAST = TW'(ACK_CYC - 1);
    localparam logic [TW-1:0] MIN_LEN = TW'(MIN_CYC);
    localparam logic [TW-1:0] SHORT_LEN = TW'(SHORT_MAX_CYC);
    localparam logic [TW-1:0] LONG_LEN = TW'(LONG_MAX_CYC);
    localparam logic [4:0] CMD_LEN = 5'(`CMD_BITS);

    one_wire_dimming_pkg::power_state_e state_q;
    one_wire_dimming_pkg::dim_mode_e mode_q;
    one_wire_dimming_pkg::command_s cmd;
    logic [1:0] line_sync_q, pwm_sync_q;
    logic line_prev_q;
    logic [TW-1:0] phase_cnt_q, pwm_low_cnt_q, timer_q, ack_cnt_q, low_len_q;
    logic entry_armed_q, serial_seen_q;
    logic rx_active_q;
    logic [4:0] bit_cnt_q;
    logic [23:0] shift_q;
    logic [7:0] level_q;
    logic ack_q;
    logic [1:0] ack_tail_q;

    // Two-stage synchronisers on both pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_sync_q <= 2'h3;
            pwm_sync_q <= 2'h0;
        end else begin
            line_sync_q <= {line_sync_q[0], single_wire_line_level};
            pwm_sync_q <= {pwm_sync_q[0], pwm_dim_level};
        end
    end

    // Our own acknowledge, and its echo through the synchroniser, reads as high
    wire line = line_sync_q[1] | ack_q | ack_tail_q[0] | ack_tail_q[1];
    wire pwm = pwm_sync_q[1];
    wire line_rise = line & ~line_prev_q;
    wire line_fall = ~line & line_prev_q;
    wire [TW-1:0] phase_len = phase_cnt_q + 1'b1;
    wire [TW:0] high_x2 = {phase_len, 1'b0};
    wire [TW:0] low_x2 = {low_len_q, 1'b0};
    wire powered = (state_q != one_wire_dimming_pkg::PWR_OFF);

    // Shutdown timeouts on the line and on the pulse-width input
    // At the falling edge phase_len still holds the high phase, so that cycle is left out
    wire en_off = ~line & ~line_fall & (phase_len >= TW'(EN_OFF_CYC));
    wire pwm_off = ~pwm & (pwm_low_cnt_q >= TW'(PWM_OFF_CYC - 1));
    wire shutdown = powered & (en_off | pwm_off);

    // Bit classification: low phase in low_len_q, high phase now ending
    wire low_ok = (low_len_q >= MIN_LEN) & (low_len_q <= LONG_LEN);
    wire high_ok = (phase_len >= MIN_LEN) & (phase_len <= LONG_LEN);
    wire is_zero = high_ok & low_ok & (phase_len <= SHORT_LEN)
                 & ({1'b0, low_len_q} >= high_x2);
    wire is_one = high_ok & low_ok & (low_len_q <= SHORT_LEN)
                & ({1'b0, phase_len} >= low_x2);
    wire rx_on = powered & (state_q != one_wire_dimming_pkg::PWR_SELECT)
               & (mode_q == one_wire_dimming_pkg::MODE_SERIAL);
    wire rx_start = rx_on & ~rx_active_q & line_fall & (phase_len >= MIN_LEN);
    wire rx_bit = rx_active_q & line_fall & (bit_cnt_q != CMD_LEN) & (is_zero | is_one);
    wire rx_end = rx_active_q & line_rise & (bit_cnt_q == CMD_LEN)
                & (phase_len >= MIN_LEN) & (phase_len <= LONG_LEN);
    wire rx_abort = rx_active_q & ((line_fall & ~rx_bit) | (line_rise & ~rx_end
                  & (bit_cnt_q == CMD_LEN)) | (phase_len > LONG_LEN));
    assign cmd = shift_q;
    wire load_hit = rx_end & (cmd.addr == `DEVICE_ADDR);

    // Phase length of the line, saturating; pulse-width low length
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_prev_q <= 1'b1;
            phase_cnt_q <= '0;
            pwm_low_cnt_q <= '0;
        end else begin
            line_prev_q <= line;
            phase_cnt_q <= (line_rise | line_fall) ? '0 : (&phase_len ? phase_cnt_q : phase_len);
            pwm_low_cnt_q <= (pwm | &pwm_low_cnt_q) ? (pwm ? '0 : pwm_low_cnt_q)
                           : pwm_low_cnt_q + 1'b1;
        end
    end

    // Power sequence: enable, mode window, boost start delay, run
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= one_wire_dimming_pkg::PWR_OFF;
            mode_q <= one_wire_dimming_pkg::MODE_PWM;
            timer_q <= '0;
        end else if (shutdown) begin
            state_q <= one_wire_dimming_pkg::PWR_OFF;
            timer_q <= '0;
        end else begin
            timer_q <= timer_q + 1'b1;
            case (state_q)
                one_wire_dimming_pkg::PWR_OFF: begin
                    timer_q <= '0;
                    if (line & pwm) begin
                        state_q <= one_wire_dimming_pkg::PWR_SELECT;
                    end
                end
                one_wire_dimming_pkg::PWR_SELECT: begin
                    if (timer_q == SEL_LAST) begin
                        // Decided as the window closes, from the entry pattern seen during it
                        mode_q <= serial_seen_q ? one_wire_dimming_pkg::MODE_SERIAL
                                                : one_wire_dimming_pkg::MODE_PWM;
                        state_q <= one_wire_dimming_pkg::PWR_DELAY;
                        timer_q <= '0;
                    end
                end
                one_wire_dimming_pkg::PWR_DELAY: begin
                    if (timer_q == DELAY_LAST) begin
                        state_q <= one_wire_dimming_pkg::PWR_RUN;
                    end
                end
                one_wire_dimming_pkg::PWR_RUN: begin
                    timer_q <= '0;
                end
                default: begin
                    state_q <= one_wire_dimming_pkg::PWR_OFF;
                end
            endcase
        end
    end

    // Serial entry pattern: long first high, then a long low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            entry_armed_q <= 1'b0;
            serial_seen_q <= 1'b0;
        end else if (state_q != one_wire_dimming_pkg::PWR_SELECT) begin
            entry_armed_q <= 1'b0;
            serial_seen_q <= 1'b0;
        end else begin
            if (line_fall & (phase_len >= TW'(ENTRY_HIGH_CYC))) begin
                entry_armed_q <= 1'b1;
            end
            if (entry_armed_q & ~line & ~line_fall & (phase_len >= TW'(ENTRY_LOW_CYC))) begin
                serial_seen_q <= 1'b1;
            end
        end
    end

    // Frame receiver: a bit is a low phase then a high phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_active_q <= 1'b0;
            bit_cnt_q <= '0;
            shift_q <= '0;
            low_len_q <= '0;
        end else if (!rx_on | rx_abort | rx_end) begin
            rx_active_q <= 1'b0;
            bit_cnt_q <= '0;
        end else begin
            if (rx_start) begin
                rx_active_q <= 1'b1;
                bit_cnt_q <= '0;
            end
            if (rx_active_q & line_rise) begin
                low_len_q <= phase_len;
            end
            if (rx_bit) begin
                shift_q <= {is_one, shift_q[23:1]};
                bit_cnt_q <= bit_cnt_q + 1'b1;
            end
        end
    end

    // Command-loaded level, cleared by shutdown
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_q <= `LEVEL_DEFAULT;
        end else if (!powered) begin
            level_q <= `LEVEL_DEFAULT;
        end else if (load_hit) begin
            level_q <= cmd.data[`LEVEL_LSB +: 8];
        end
    end

    // Acknowledge starts on the release edge, so the delay is only synchroniser latency
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            ack_cnt_q <= '0;
            ack_tail_q <= 2'h0;
        end else begin
            ack_tail_q <= {ack_tail_q[0], ack_q};
            if (load_hit & cmd.data[`ACK_REQ_BIT]) begin
                ack_q <= 1'b1;
                ack_cnt_q <= '0;
            end else if (ack_q) begin
                ack_cnt_q <= ack_cnt_q + 1'b1;
                ack_q <= (ack_cnt_q != ACK_LAST) & powered;
            end
        end
    end

    assign single_wire_line_pull = 1'b0;
    assign single_wire_line_oe = ack_q;

    // Registered sink drive and status
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sink_ctrl <= '0;
            drive_status <= '0;
        end else begin
            sink_ctrl.current_sink_one_on <= (state_q == one_wire_dimming_pkg::PWR_RUN) & pwm;
            sink_ctrl.current_sink_two_on <= (state_q == one_wire_dimming_pkg::PWR_RUN) & pwm;
            sink_ctrl.level <= (mode_q == one_wire_dimming_pkg::MODE_SERIAL)
                             ? level_q : `LEVEL_DEFAULT;
            drive_status.enabled <= powered;
            drive_status.serial_mode <= mode_q == one_wire_dimming_pkg::MODE_SERIAL;
            drive_status.boost_on <= state_q == one_wire_dimming_pkg::PWR_RUN;
            drive_status.ack_active <= ack_q;
        end
    end

    property p_ack_requested;
        @(posedge clk) disable iff (!reset_n)
        $rose(ack_q) |-> $past(load_hit && cmd.data[`ACK_REQ_BIT]);
    endproperty
    a_ack_requested: assert property (p_ack_requested) else $error("ack without request");

    property p_ack_prompt;
        @(posedge clk) disable iff (!reset_n)
        (load_hit && cmd.data[`ACK_REQ_BIT]) |=> single_wire_line_oe;
    endproperty
    a_ack_prompt: assert property (p_ack_prompt) else $error("ack not started");

    property p_ack_bounded;
        @(posedge clk) disable iff (!reset_n)
        ack_q |-> (ack_cnt_q <= ACK_LAST);
    endproperty
    a_ack_bounded: assert property (p_ack_bounded) else $error("ack too long");

    property p_en_shutdown;
        @(posedge clk) disable iff (!reset_n)
        (powered && !line && !line_fall && phase_len >= TW'(EN_OFF_CYC))
        |=> !powered ##1 level_q == 8'hFF;
    endproperty
    a_en_shutdown: assert property (p_en_shutdown) else $error("no line shutdown");

    property p_pwm_shutdown;
        @(posedge clk) disable iff (!reset_n)
        (powered && !pwm && pwm_low_cnt_q >= TW'(PWM_OFF_CYC - 1)) |=> !powered;
    endproperty
    a_pwm_shutdown: assert property (p_pwm_shutdown) else $error("no pwm shutdown");

    property p_mode_pick;
        @(posedge clk) disable iff (!reset_n)
        (state_q == one_wire_dimming_pkg::PWR_SELECT && timer_q == SEL_LAST && !shutdown)
        |=> (mode_q == one_wire_dimming_pkg::MODE_SERIAL) == $past(serial_seen_q);
    endproperty
    a_mode_pick: assert property (p_mode_pick) else $error("wrong dimming mode");

    property p_boost_delay;
        @(posedge clk) disable iff (!reset_n)
        (state_q == one_wire_dimming_pkg::PWR_RUN && $past(state_q) != state_q)
        |-> $past(timer_q) == DELAY_LAST;
    endproperty
    a_boost_delay: assert property (p_boost_delay) else $error("boost started early");

    property p_bit_value;
        @(posedge clk) disable iff (!reset_n)
        rx_bit |=> shift_q[23] == $past(is_one) && $past(is_one) != $past(is_zero);
    endproperty
    a_bit_value: assert property (p_bit_value) else $error("bit decoded wrongly");

    property p_level;
        @(posedge clk) disable iff (!reset_n)
        load_hit |=> ##1 sink_ctrl.level == $past(cmd.data[8:1], 2) || !powered;
    endproperty
    a_level: assert property (p_level) else $error("level not applied");

    property p_sync;
        @(posedge clk) disable iff (!reset_n)
        ##2 pwm == $past(pwm_dim_level, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("pwm not synchronised");

endmodule : one_wire_dimming_control

/* rtl/one_wire_dimming_defines.svh */
`ifndef ONE_WIRE_DIMMING_DEFINES_SVH
`define ONE_WIRE_DIMMING_DEFINES_SVH

// Oscillator period
`define CLK_PERIOD_NS 40

// Mode selection and power timing, in ns
`define SEL_MIN_NS 1000000
`define SEL_MAX_NS 2200000
`define ENTRY_HIGH_NS 100000
`define ENTRY_LOW_NS 260000
`define EN_OFF_NS 2500000
`define PWM_OFF_NS 20000000
`define START_DELAY_NS 5000000

// Single-wire bit timing, in ns
`define PHASE_MIN_NS 2000
`define BIT_SHORT_MAX_NS 180000
`define BIT_LONG_MAX_NS 360000
`define ACK_DELAY_MAX_NS 2000
`define ACK_MAX_NS 512000

// Command layout
`define CMD_BITS 24
`define DEVICE_ADDR 8'h8F
`define ACK_REQ_BIT 10
`define LEVEL_LSB 1
`define LEVEL_DEFAULT 8'hFF

`endif

/* rtl/one_wire_dimming_pkg.sv */
package one_wire_dimming_pkg;

    typedef enum logic [1:0] {PWR_OFF, PWR_SELECT, PWR_DELAY, PWR_RUN} power_state_e;

    typedef enum logic {MODE_PWM, MODE_SERIAL} dim_mode_e;

    // Received command, sent low bit first
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } command_s;

    // Drive to both current sinks; current = full scale * level / 255
    typedef struct packed {
        logic current_sink_one_on;
        logic current_sink_two_on;
        logic [7:0] level;
    } sink_ctrl_s;

    typedef struct packed {
        logic enabled;
        logic serial_mode;
        logic boost_on;
        logic ack_active;
    } drive_status_s;

endpackage : one_wire_dimming_pkg
